//--- logic/jtag_idscan_consts.vh
`ifndef JTAG_IDSCAN_CONSTS_VH
`define JTAG_IDSCAN_CONSTS_VH

// ----------------------------------------
// Instruction register layout and codes
// ----------------------------------------
`define IR_WIDTH 4
`define IR_CAPTURE_VALUE 4'h1
`define INSTR_IDCODE 4'h1
`define INSTR_BYPASS 4'hf

// ----------------------------------------
// Identification register
// ----------------------------------------
`define ID_WIDTH 32
// Arbitrary neutral value, bit 0 set as the scan standard expects
`define ID_VALUE 32'h0000_0001

// ----------------------------------------
// Test access port states, one-hot
// ----------------------------------------
`define TAP_STATES 16
`define ST_RESET 16'h0001
`define ST_IDLE 16'h0002
`define ST_SEL_DR 16'h0004
`define ST_CAP_DR 16'h0008
`define ST_SHIFT_DR 16'h0010
`define ST_EXIT1_DR 16'h0020
`define ST_PAUSE_DR 16'h0040
`define ST_EXIT2_DR 16'h0080
`define ST_UPD_DR 16'h0100
`define ST_SEL_IR 16'h0200
`define ST_CAP_IR 16'h0400
`define ST_SHIFT_IR 16'h0800
`define ST_EXIT1_IR 16'h1000
`define ST_PAUSE_IR 16'h2000
`define ST_EXIT2_IR 16'h4000
`define ST_UPD_IR 16'h8000

`endif

//--- logic/jtag_idscan_port.v
`timescale 1ns/1ps
`default_nettype none
`include "jtag_idscan_consts.vh"

module jtag_idscan_port
(
    input wire mclk_in,
    input wire reset_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    output reg id_selected_out,
    output reg [`IR_WIDTH-1:0] instr_out,
    output reg [`TAP_STATES-1:0] tap_state_out
);

    // ----------------------------------------
    // State codes
    // ----------------------------------------
    localparam [15:0] S_RESET = `ST_RESET;
    localparam [15:0] S_IDLE = `ST_IDLE;
    localparam [15:0] S_SEL_DR = `ST_SEL_DR;
    localparam [15:0] S_CAP_DR = `ST_CAP_DR;
    localparam [15:0] S_SHIFT_DR = `ST_SHIFT_DR;
    localparam [15:0] S_EXIT1_DR = `ST_EXIT1_DR;
    localparam [15:0] S_PAUSE_DR = `ST_PAUSE_DR;
    localparam [15:0] S_EXIT2_DR = `ST_EXIT2_DR;
    localparam [15:0] S_UPD_DR = `ST_UPD_DR;
    localparam [15:0] S_SEL_IR = `ST_SEL_IR;
    localparam [15:0] S_CAP_IR = `ST_CAP_IR;
    localparam [15:0] S_SHIFT_IR = `ST_SHIFT_IR;
    localparam [15:0] S_EXIT1_IR = `ST_EXIT1_IR;
    localparam [15:0] S_PAUSE_IR = `ST_PAUSE_IR;
    localparam [15:0] S_EXIT2_IR = `ST_EXIT2_IR;
    localparam [15:0] S_UPD_IR = `ST_UPD_IR;

    // ----------------------------------------
    // Pin synchronisers and test clock edges
    // ----------------------------------------
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    reg tck_d;
    wire tck_rise;
    wire tck_fall;

    sync_two_flop u_sync_tck
    (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(tck_in),
        .sync_out(tck_s)
    );

    sync_two_flop u_sync_tms
    (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(tms_in),
        .sync_out(tms_s)
    );

    sync_two_flop u_sync_tdi
    (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(tdi_in),
        .sync_out(tdi_s)
    );

    // Same delay on all three pins keeps mode and data aligned to the clock edge
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            tck_d <= 1'b0;
        else
            tck_d <= tck_s;
    end

    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // ----------------------------------------
    // Port state machine
    // ----------------------------------------
    reg [15:0] state;
    reg [15:0] next_state;

    // Standard transition graph steered by the mode pin
    always @*
    begin
        case (state)
            S_RESET: next_state = tms_s ? S_RESET : S_IDLE;
            S_IDLE: next_state = tms_s ? S_SEL_DR : S_IDLE;
            S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: next_state = tms_s ? S_EXIT1_DR : S_SHIFT_DR;
            S_SHIFT_DR: next_state = tms_s ? S_EXIT1_DR : S_SHIFT_DR;
            S_EXIT1_DR: next_state = tms_s ? S_UPD_DR : S_PAUSE_DR;
            S_PAUSE_DR: next_state = tms_s ? S_EXIT2_DR : S_PAUSE_DR;
            S_EXIT2_DR: next_state = tms_s ? S_UPD_DR : S_SHIFT_DR;
            S_UPD_DR: next_state = tms_s ? S_SEL_DR : S_IDLE;
            S_SEL_IR: next_state = tms_s ? S_RESET : S_CAP_IR;
            S_CAP_IR: next_state = tms_s ? S_EXIT1_IR : S_SHIFT_IR;
            S_SHIFT_IR: next_state = tms_s ? S_EXIT1_IR : S_SHIFT_IR;
            S_EXIT1_IR: next_state = tms_s ? S_UPD_IR : S_PAUSE_IR;
            S_PAUSE_IR: next_state = tms_s ? S_EXIT2_IR : S_PAUSE_IR;
            S_EXIT2_IR: next_state = tms_s ? S_UPD_IR : S_SHIFT_IR;
            S_UPD_IR: next_state = tms_s ? S_SEL_DR : S_IDLE;
            default: next_state = S_RESET;
        endcase
    end

    // State advances only on a test clock rising edge
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            state <= S_RESET;
        else if (tck_rise)
            state <= next_state;
    end

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    reg [`IR_WIDTH-1:0] ir_shift;
    reg [`IR_WIDTH-1:0] ir;
    wire id_sel;

    // Only the identification code selects the identification register
    assign id_sel = (ir == `INSTR_IDCODE);

    // Capture and shift on rise, update and default load on fall
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ir_shift <= `IR_CAPTURE_VALUE;
            ir <= `INSTR_IDCODE;
        end
        else if (tck_rise)
        begin
            if (state == S_CAP_IR)
                ir_shift <= `IR_CAPTURE_VALUE;
            else if (state == S_SHIFT_IR)
                ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
        end
        else if (tck_fall)
        begin
            if (state == S_RESET)
                ir <= `INSTR_IDCODE;
            else if (state == S_UPD_IR)
                ir <= ir_shift;
        end
    end

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    reg [`ID_WIDTH-1:0] id_shift;
    reg bypass_bit;

    // The identification path keeps the defect: a one enters instead of the
    // input pin, so everything clocked through it from upstream turns to ones
    // and whatever reaches downstream members before their update is ones too.
    // Bypass and every unknown instruction use the single bypass stage.
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            id_shift <= `ID_VALUE;
            bypass_bit <= 1'b0;
        end
        else if (tck_rise)
        begin
            if (state == S_CAP_DR)
            begin
                id_shift <= `ID_VALUE;
                bypass_bit <= 1'b0;
            end
            else if (state == S_SHIFT_DR)
            begin
                if (id_sel)
                    id_shift <= {1'b1, id_shift[`ID_WIDTH-1:1]};
                else
                    bypass_bit <= tdi_s;
            end
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    // Output changes on the falling edge so the next stage samples it stably
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end
        else if (tck_fall)
        begin
            if (state == S_SHIFT_DR)
            begin
                tdo_oe_out <= 1'b1;
                tdo_out <= id_sel ? id_shift[0] : bypass_bit;
            end
            else if (state == S_SHIFT_IR)
            begin
                tdo_oe_out <= 1'b1;
                tdo_out <= ir_shift[0];
            end
            else
            begin
                tdo_oe_out <= 1'b0;
                tdo_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    // Registered copies for observation; a test controller keeps downstream
    // members idle while the identification register is selected
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            id_selected_out <= 1'b1;
            instr_out <= `INSTR_IDCODE;
            tap_state_out <= S_RESET;
        end
        else
        begin
            id_selected_out <= id_sel;
            instr_out <= ir;
            tap_state_out <= state;
        end
    end

endmodule // jtag_idscan_port

`default_nettype wire

//--- logic/sync_two_flop.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-flop synchroniser for one pin
// ----------------------------------------
module sync_two_flop
(
    input wire mclk_in,
    input wire reset_in,
    input wire async_in,
    output reg sync_out
);

    reg meta;

    // First flop feeds only the second
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // sync_two_flop

`default_nettype wire

//--- verif/jtag_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Scan controller, device first in chain
// ----------------------------------------
module jtag_ctrl_model
(
    input wire logic mclk_in,
    input wire logic tdo_in,
    input wire logic tdo_oe_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // Test clock stands low between bits; tms high keeps the port in reset
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One test clock of 80 ns; tdi comes straight from us, nothing upstream
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge mclk_in);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (4) @(posedge mclk_in);
        tdo = tdo_oe_in ? tdo_in : 1'b1; // Released line reads its pull-up
        tck_out <= 1'b1;
        repeat (5) @(posedge mclk_in);
        tck_out <= 1'b0;
    endtask
endmodule // jtag_ctrl_model
`default_nettype wire

//--- verif/jtag_idscan_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtag_idscan_consts.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module jtag_idscan_port_monitor
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic id_selected_out,
    input wire logic [`IR_WIDTH-1:0] instr_out,
    input wire logic [`TAP_STATES-1:0] tap_state_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    logic tck_prev;
    logic [6:0] shift_cnt;
    // Count data shift rises since capture; saturates so a long scan cannot wrap
    always @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tck_prev <= 1'b0;
            shift_cnt <= 7'h00;
        end
        else
        begin
            tck_prev <= tck_in;
            if (tap_state_out == `ST_CAP_DR)
                shift_cnt <= 7'h00;
            else if (tck_in && !tck_prev && tap_state_out == `ST_SHIFT_DR && shift_cnt != 7'h7f)
                shift_cnt <= shift_cnt + 7'h01;
        end
    end
    // Past the whole id word only forced ones may leave the id path
    a_id_fills_ones: assert property (shift_cnt > 7'd32 && id_selected_out &&
        tdo_oe_out && tap_state_out == `ST_SHIFT_DR |-> tdo_out)
        else $error("upstream bit not forced to one");
    // Sync delay is under half a test clock, so pin level still shows the edge
    a_state_on_rise: assert property ($changed(tap_state_out) |-> tck_in)
        else $error("state moved outside tck high");
    a_tdo_on_fall: assert property ($changed(tdo_out) |-> !tck_in)
        else $error("tdo moved outside tck low");
    a_oe_in_shift: assert property (tdo_oe_out |-> |(tap_state_out & (`ST_SHIFT_DR |
        `ST_EXIT1_DR | `ST_SHIFT_IR | `ST_EXIT1_IR)))
        else $error("tdo enabled outside shift");
    a_tdo_quiet: assert property (!tdo_oe_out && !$past(tdo_oe_out) |-> !tdo_out)
        else $error("tdo high while idle");
    a_reset_loads_id: assert property ($rose(tap_state_out == `ST_RESET)
        |-> ##[1:20] instr_out == `INSTR_IDCODE)
        else $error("reset state kept old instruction");
    a_instr_update: assert property ($changed(instr_out) |-> !tck_in &&
        (tap_state_out == `ST_UPD_IR || tap_state_out == `ST_RESET))
        else $error("instruction changed outside update");
    a_id_flag_set: assert property (instr_out == `INSTR_IDCODE &&
        $past(instr_out) == `INSTR_IDCODE |-> id_selected_out)
        else $error("id flag low with id instruction");
    a_bypass_no_id: assert property (instr_out == `INSTR_BYPASS &&
        $past(instr_out) == `INSTR_BYPASS |-> !id_selected_out)
        else $error("id flag high with bypass");
endmodule // jtag_idscan_port_monitor

bind jtag_idscan_port jtag_idscan_port_monitor mon (.mclk_in, .reset_in, .tck_in, .tms_in,
    .tdi_in, .tdo_out, .tdo_oe_out, .id_selected_out, .instr_out, .tap_state_out);
`default_nettype wire

//--- verif/jtag_idscan_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtag_idscan_consts.vh"
// ----------------------------------------
// Testbench
// ----------------------------------------
module jtag_idscan_port_tb;
    logic mclk_in;
    logic reset_in;
    logic t;
    wire tck, tms, tdi, tdo, oe, idsel;
    wire [`IR_WIDTH-1:0] instr;
    wire [`TAP_STATES-1:0] st;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    // 125 MHz system clock
    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    jtag_idscan_port dut (.mclk_in(mclk_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(oe), .id_selected_out(idsel),
        .instr_out(instr), .tap_state_out(st));
    jtag_ctrl_model m (.mclk_in(mclk_in), .tdo_in(tdo), .tdo_oe_in(oe), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Walk the state graph with tdi low
    task automatic go(input logic [15:0] s, input int n);
        for (int i = 0; i < n; i++)
            m.step(s[i], 1'b0, t);
    endtask
    // Shift n bits, leaving on the last, and compare every bit out
    task automatic shift(input int n, input logic [63:0] din, input logic [63:0] exp);
        for (int i = 0; i < n; i++)
        begin
            m.step(i == n - 1, din[i], t);
            check(t, exp[i]);
        end
    endtask
    task automatic t_reset_state();
        check(instr, `INSTR_IDCODE);
        check(st, `ST_RESET);
        check({idsel, oe}, 2'b10);
    endtask
    // Id then upstream data; upstream bits must come out as ones
    task automatic t_id_scan();
        go(16'h0002, 4);
        shift(64, 64'h5a3c_0f96_c3a5_6912, {32'hffff_ffff, `ID_VALUE});
        go(16'h0001, 2); // No downstream data is meant here
    endtask
    // Load bypass, then one stage from tdi to tdo
    task automatic t_bypass();
        go(16'h0003, 4);
        shift(4, `INSTR_BYPASS, `IR_CAPTURE_VALUE);
        go(16'h0001, 2);
        check(instr, `INSTR_BYPASS);
        check(idsel, 1'b0);
        go(16'h0002, 4);
        shift(9, 64'h0b4, 64'h168);
        go(16'h0001, 2);
    endtask
    // Five high tms bits reach reset and restore the id instruction
    task automatic t_logic_reset();
        go(16'h001f, 5);
        repeat (20) @(posedge mclk_in);
        t_reset_state();
    endtask
    // Hang guard, far above the ~1730 cycles the run needs
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        reset_in = 1'b1;
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        t_reset_state();
        t_id_scan();
        t_bypass();
        t_logic_reset();
        t_id_scan();
        summarize();
    end
endmodule // jtag_idscan_port_tb
`default_nettype wire
